// *** bench/core_seq_model.sv ***
/* core sequencer model: running pc and shadow source registers.
   assumes one clock shared with the stack. */
`timescale 1ns/1ps
module core_seq_model (
  input wire logic sys_clk,
  output logic [20:0] pc,
  output logic [7:0] st,
  output logic [7:0] wk,
  output logic [3:0] bk
);
  initial {pc, st, wk, bk} = {21'h01234, 8'h5A, 8'hC3, 4'h9};
  // pc steps by a word, shadow sources move every cycle so a stale save shows
  always_ff @(posedge sys_clk) begin
    pc <= pc + 21'h000002;
    st <= st + 8'h11;
    wk <= wk + 8'h07;
    bk <= bk + 4'h3;
  end
endmodule // core_seq_model

// *** bench/ret_stack_monitor.sv ***
/* checker for the return address stack: port-level timing of pops,
   restores and register reads. assumes the top module port names. */
`timescale 1ns/1ps
module ret_stack_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic extended_set_enable,
  input wire logic call_push,
  input wire logic int_ack_push,
  input wire logic sw_push,
  input wire logic ret_pop,
  input wire logic unlink_pop,
  input wire logic sw_pop,
  input wire logic fast_restore,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [20:0] pc_load,
  input wire logic pc_load_valid,
  input wire logic restore_valid
);
  // push strobes win over pops, so pops are judged only without one
  wire logic psh = call_push | int_ack_push | sw_push;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ret_pop_a: assert property (ret_pop && !psh |=> pc_load_valid)
    else $error("return pop gave no pc load");
  sw_pop_a: assert property (sw_pop && !ret_pop && !unlink_pop && !psh |=> !pc_load_valid)
    else $error("software pop loaded the pc");
  unlink_gate_a: assert property (unlink_pop && !extended_set_enable && !ret_pop
    && !sw_pop && !psh |=> !pc_load_valid)
    else $error("unlink popped without extended set");
  pc_even_a: assert property (pc_load_valid |-> !pc_load[0])
    else $error("popped address odd");
  fast_ret_a: assert property (ret_pop && fast_restore && !psh |=> restore_valid)
    else $error("fast return gave no restore");
  restore_cause_a: assert property (restore_valid |-> $past(ret_pop && fast_restore))
    else $error("restore without fast return");
  ptr_bit5_a: assert property (reg_rd && reg_addr == 3'h0 |=> !reg_rdata[5])
    else $error("pointer bit 5 read as one");
  load_cause_a: assert property (pc_load_valid |-> $past(ret_pop || unlink_pop))
    else $error("pc load without pop");
endmodule // ret_stack_monitor
bind return_address_stack ret_stack_monitor mon (.*);

// *** bench/tb_top.sv ***
/* self-checking bench for the return address stack.
   assumes register port and command pulses on one 50 MHz clock. */
`timescale 1ns/1ps
module tb_top;
  import ret_stack_pkg::*;
  logic sys_clk = 0, rstn = 0, por_n = 0, ext = 0, wr = 0, rd = 0;
  logic [7:0] cv = 0, wd = 0, rdv, st, wk, sr, wr_q;
  logic [2:0] ra = 0;
  logic [3:0] bk, br;
  logic [19:0] f, g;
  addr_type pc, pc_low_byte, e, t, q[$];
  logic plv, rsv, srr;
  int bad_count = 0, n_tests = 0, rq = 0, k;
  always #10 sys_clk = ~sys_clk;
  core_seq_model core (.sys_clk(sys_clk), .pc(pc), .st(st), .wk(wk), .bk(bk));
  return_address_stack uut (.sys_clk(sys_clk), .rstn(rstn), .por_n(por_n),
    .extended_set_enable(ext), .call_push(cv[0]), .int_ack_push(cv[1]), .sw_push(cv[2]),
    .ret_pop(cv[3]), .unlink_pop(cv[4]), .sw_pop(cv[5]), .fast_save(cv[6]),
    .fast_restore(cv[7]), .pc_in(pc), .status_in(st), .working_register_in(wk),
    .bank_select_register_in(bk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdv), .pc_load(pc_low_byte), .pc_load_valid(plv), .status_restore(sr),
    .working_register_restore(wr_q), .bank_select_register_restore(br),
    .restore_valid(rsv), .stack_reset_req(srr));
  // reset requests are counted, a pulse is one cycle only
  always @(posedge sys_clk) if (srr === 1'b1) rq++;
  task automatic chk(string n, logic [20:0] s, logic [20:0] x);
    n_tests++;
    if (s !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wrr(logic [2:0] a, logic [7:0] d);
    @(posedge sys_clk); wr <= 1; ra <= a; wd <= d;
    @(posedge sys_clk); wr <= 0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdr(logic [2:0] a, logic [7:0] x);
    @(posedge sys_clk); rd <= 1; ra <= a;
    @(posedge sys_clk); rd <= 0;
    #1 chk("reg", rdv, x);
  endtask
  // one command cycle; pc and shadow sources taken as the design sees them
  task automatic go(logic [7:0] v);
    @(posedge sys_clk); cv <= v;
    @(posedge sys_clk); e = pc; f = {st, wk, bk}; cv <= 0;
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1; por_n <= 1;
    rdr(0, 8'h00);
    rdr(4, 8'h01);
    wrr(4, 8'h00);
    for (k = 0; k < 3; k++) begin
      go(8'h01 << k); q.push_back(e);
      rdr(0, k + 1);
      rdr(1, e[7:0]);
      rdr(3, e[20:16]);
    end
    go(8'h08); chk("pop", {plv, pc_low_byte}, {1'b1, q.pop_back()});
    go(8'h10); rdr(0, 8'h02);
    ext <= 1; go(8'h10); chk("unlink", pc_low_byte, q.pop_back());
    go(8'h20); rdr(0, 8'h00);
    go(8'h08); chk("under", pc_low_byte, 21'h0);
    rdr(0, 8'h40);
    wrr(0, 8'h00); rdr(0, 8'h00);
    wrr(0, 8'h05); wrr(1, 8'hFF); rdr(1, 8'hFE);
    rdr(0, 8'h05);
    wrr(0, 8'h1E); go(8'h01); t = e; rdr(0, 8'h9F);
    go(8'h01); rdr(0, 8'h9F); rdr(1, t[7:0]);
    chk("noreq", rq, 0);
    @(posedge sys_clk); por_n <= 0; repeat (4) @(posedge sys_clk); por_n <= 1;
    rdr(0, 8'h1F);
    wrr(4, 8'h01); wrr(0, 8'h1E); go(8'h01);
    repeat (3) @(posedge sys_clk);
    rdr(0, 8'h80); chk("req", rq, 1);
    // point back at entry 31, full kept, to see the pc plus two value
    wrr(0, 8'h9F); rdr(1, e[7:0] + 8'h02);
    wrr(0, 8'h80);
    go(8'h41); g = f;
    go(8'h88); chk("fastcall", {rsv, sr, wr_q, br}, {1'b1, g});
    go(8'h41); go(8'h02); g = f;
    go(8'h88); chk("shadow", {rsv, sr, wr_q, br}, {1'b1, g});
    test_done;
  end
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
endmodule // tb_top

// *** logic/ret_stack_map.svh ***
/*
  Constants for the return address stack: register offsets, field positions,
  reset values and sizes. Assumes inclusion by bare name from the design files.
*/
`ifndef RET_STACK_MAP_SVH
`define RET_STACK_MAP_SVH

// register offsets on the plain register port
`define REG_STACK_POINTER 3'h0
`define REG_TOP_LOW 3'h1
`define REG_TOP_HIGH 3'h2
`define REG_TOP_UPPER 3'h3
`define REG_CONFIG 3'h4

// stack pointer register fields
`define FULL_BIT 7
`define UNDERFLOW_BIT 6
`define PTR_MSB 4

// sizes and reset values
`define STACK_DEPTH 5'h1F
`define PTR_RESET 5'h00
`define CONFIG_RESET 8'h01

`endif

// *** logic/ret_stack_pkg.sv ***
/*
  Types for the return address stack.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ret_stack_pkg;
  typedef logic [20:0] addr_type;
  typedef logic [4:0] ptr_type;
  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_PUSH = 3'b010,
    OP_POP = 3'b100
  } op_type;
endpackage

// *** logic/return_address_stack.sv ***
/*
  Return address stack: 31 x 21-bit hardware stack, pointer and flags,
  top-of-stack registers, one-level fast shadow store.
  Assumes the core sequencer drives one-cycle command pulses on sys_clk and
  that the register port is a same-clock master with one-cycle strobes.
*/
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ret_stack_map.svh"

// Function
// - stack is 31 words of 21 bits, 5-bit pointer, own address space.
// - call, relative call and interrupt acknowledge push the pc.
// - returns pop; add/subtract unlink also pop with extended set.
// - calls and returns leave upper and high pc latches untouched.
// - push increments pointer first, then writes pc to new entry.
// - pop reads entry at pointer, then decrements pointer.
// - reset clears pointer; pointer zero has no storage, empty only.
// - upper, high, low top registers access entry at pointer.
// - software reads and writes pointer, range 0 to 31.
// - full flag sets after 31 pushes without a pop.
// - with error reset, 31st push stores pc plus two, flags, resets.
// - without error reset, pointer stays 31, entry 31 not overwritten.
// - pop at zero returns zero, sets underflow, pointer stays zero.
// - error reset enable decides whether full/underflow reset the device.
// - flags bits 7 and 6 sticky until software or power-on clears.
// - pointer in bits 4..0, bit 5 reads zero.
// - software push increments pointer and stores current pc.
// - software pop only decrements pointer.
// - one-level shadow of status, working, bank select; not software visible.
// - every interrupt vectoring captures shadow, nesting overwrites.
// - fast call saves shadow; fast return restores all three.
// - pc bit 0 held zero on every stored or restored address.
module return_address_stack
  import ret_stack_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic extended_set_enable,
  input wire logic call_push,
  input wire logic int_ack_push,
  input wire logic sw_push,
  input wire logic ret_pop,
  input wire logic unlink_pop,
  input wire logic sw_pop,
  input wire logic fast_save,
  input wire logic fast_restore,
  input wire logic [20:0] pc_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_register_in,
  input wire logic [3:0] bank_select_register_in,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [20:0] pc_load,
  output logic pc_load_valid,
  output logic [7:0] status_restore,
  output logic [7:0] working_register_restore,
  output logic [3:0] bank_select_register_restore,
  output logic restore_valid,
  output logic stack_reset_req
);

  addr_type stack_mem [1:31];
  ptr_type ptr_q;
  logic stack_full_flag_q;
  logic stack_underflow_flag_q;
  logic stack_error_reset_enable_q;
  logic [7:0] shadow_status_q;
  logic [7:0] shadow_working_q;
  logic [3:0] shadow_bank_q;
  logic por_meta_q;
  logic por_sync_q;
  logic reset_pending_q;
  op_type op;
  logic do_push;
  logic do_pop;
  logic hw_pop;
  logic at_full;
  addr_type top_word;
  addr_type push_value;
  logic sw_wr_ptr;
  logic sw_wr_top;
  ptr_type ptr_d;

  // power-on strap synchronised; only the second stage is read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_meta_q <= 1'b0;
      por_sync_q <= 1'b0;
    end else begin
      por_meta_q <= por_n;
      por_sync_q <= por_meta_q;
    end
  end

  // command decode; unlink pops only with the extended set
  assign hw_pop = ret_pop | (unlink_pop & extended_set_enable);
  assign do_push = call_push | int_ack_push | sw_push;
  assign do_pop = hw_pop | sw_pop;
  always_comb begin
    if (do_push) begin
      op = OP_PUSH;
    end else if (do_pop) begin
      op = OP_POP;
    end else begin
      op = OP_NONE;
    end
  end

  assign at_full = (ptr_q == `STACK_DEPTH);
  assign top_word = (ptr_q == `PTR_RESET) ? 21'h000000 : stack_mem[ptr_q];
  // the entry at 30->31 with error reset enabled takes pc plus two
  assign push_value = (ptr_q == 5'h1E && stack_error_reset_enable_q) ?
                      (pc_in + 21'h000002) & 21'h1FFFFE :
                      pc_in & 21'h1FFFFE;

  // software pointer and top writes lose to any same-cycle stack operation
  assign sw_wr_ptr = reg_wr && (reg_addr == `REG_STACK_POINTER) && op == OP_NONE;
  assign sw_wr_top = reg_wr && op == OP_NONE && ptr_q != `PTR_RESET &&
                     (reg_addr == `REG_TOP_LOW || reg_addr == `REG_TOP_HIGH ||
                      reg_addr == `REG_TOP_UPPER);

  // next pointer
  always_comb begin
    ptr_d = ptr_q;
    case (op)
      OP_PUSH: begin
        if (!at_full) begin
          ptr_d = ptr_q + 5'h01;
        end
      end
      OP_POP: begin
        if (ptr_q != `PTR_RESET) begin
          ptr_d = ptr_q - 5'h01;
        end
      end
      default: begin
        if (sw_wr_ptr) begin
          ptr_d = reg_wdata[`PTR_MSB:0];
        end
      end
    endcase
  end

  // pointer register; a stack error reset also drops it to zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= `PTR_RESET;
    end else if (reset_pending_q) begin
      ptr_q <= `PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // storage: push writes the new entry, software writes the top byte lanes
  always_ff @(posedge sys_clk) begin
    if (op == OP_PUSH && !at_full) begin
      stack_mem[ptr_q + 5'h01] <= push_value;
    end else if (sw_wr_top) begin
      if (reg_addr == `REG_TOP_LOW) begin
        stack_mem[ptr_q][7:0] <= {reg_wdata[7:1], 1'b0};
      end else if (reg_addr == `REG_TOP_HIGH) begin
        stack_mem[ptr_q][15:8] <= reg_wdata;
      end else begin
        stack_mem[ptr_q][20:16] <= reg_wdata[4:0];
      end
    end
  end

  // sticky flags; set wins over a software clear, software or power-on clears
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stack_full_flag_q <= 1'b0;
      stack_underflow_flag_q <= 1'b0;
    end else if (!por_sync_q) begin
      stack_full_flag_q <= 1'b0;
      stack_underflow_flag_q <= 1'b0;
    end else begin
      if (op == OP_PUSH && (ptr_q == 5'h1E || at_full)) begin
        stack_full_flag_q <= 1'b1;
      end else if (sw_wr_ptr && !reg_wdata[`FULL_BIT]) begin
        stack_full_flag_q <= 1'b0;
      end
      if (op == OP_POP && ptr_q == `PTR_RESET) begin
        stack_underflow_flag_q <= 1'b1;
      end else if (sw_wr_ptr && !reg_wdata[`UNDERFLOW_BIT]) begin
        stack_underflow_flag_q <= 1'b0;
      end
    end
  end

  // error reset enable lives in a config register; default set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stack_error_reset_enable_q <= 1'b1;
    end else if (reg_wr && reg_addr == `REG_CONFIG) begin
      stack_error_reset_enable_q <= reg_wdata[0];
    end
  end

  // device reset request two cycles after the full or underflow event
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reset_pending_q <= 1'b0;
      stack_reset_req <= 1'b0;
    end else begin
      reset_pending_q <= stack_error_reset_enable_q &&
                         ((op == OP_PUSH && ptr_q == 5'h1E) ||
                          (op == OP_POP && ptr_q == `PTR_RESET));
      stack_reset_req <= reset_pending_q;
    end
  end

  // pc reload on hardware pops only; latches are never driven from here
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc_load <= 21'h000000;
      pc_load_valid <= 1'b0;
    end else begin
      pc_load_valid <= (op == OP_POP) && hw_pop;
      if (op == OP_POP && hw_pop) begin
        pc_load <= top_word & 21'h1FFFFE;
      end
    end
  end

  // shadow store: every interrupt or fast call overwrites it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shadow_status_q <= 8'h00;
      shadow_working_q <= 8'h00;
      shadow_bank_q <= 4'h0;
    end else if (int_ack_push || (call_push && fast_save)) begin
      shadow_status_q <= status_in;
      shadow_working_q <= working_register_in;
      shadow_bank_q <= bank_select_register_in;
    end
  end

  // restore outputs on a fast return
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_restore <= 8'h00;
      working_register_restore <= 8'h00;
      bank_select_register_restore <= 4'h0;
      restore_valid <= 1'b0;
    end else begin
      restore_valid <= ret_pop && fast_restore;
      status_restore <= shadow_status_q;
      working_register_restore <= shadow_working_q;
      bank_select_register_restore <= shadow_bank_q;
    end
  end

  // register read port, data the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `REG_STACK_POINTER) begin
        reg_rdata <= {stack_full_flag_q, stack_underflow_flag_q, 1'b0, ptr_q};
      end else if (reg_addr == `REG_TOP_LOW) begin
        reg_rdata <= top_word[7:0];
      end else if (reg_addr == `REG_TOP_HIGH) begin
        reg_rdata <= top_word[15:8];
      end else if (reg_addr == `REG_TOP_UPPER) begin
        reg_rdata <= {3'h0, top_word[20:16]};
      end else if (reg_addr == `REG_CONFIG) begin
        reg_rdata <= {7'h00, stack_error_reset_enable_q};
      end else begin
        reg_rdata <= 8'h00; // unmapped
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // return_address_stack
